// ---- verilog/lcdie_pkg.sv ----
// Package for the character display instruction engine.
// Assumes a 250 MHz pclk; times are turned into cycle counts here.
package lcdie_pkg;
  localparam int CLK_NS = 4;
  localparam int CLR_TIME_NS = 1530000;
  localparam int CMD_TIME_NS = 39000;
  localparam int DATA_TIME_NS = 43000;
  // Least times, rounded up to whole cycles
  localparam int CLR_CYC = (CLR_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CMD_CYC = (CMD_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int DATA_CYC = (DATA_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_W = 20;
  localparam int TEXT_DEPTH = 80;
  localparam int GLYPH_DEPTH = 64;
  localparam logic [6:0] LINE_LEN = 7'h28;
  localparam logic [6:0] ONE_SPAN = 7'h50;
  localparam logic [6:0] HOME_ADDR = 7'h00;
  localparam logic [6:0] ONE_LAST = 7'h4f;
  localparam logic [6:0] LINE1_LAST = 7'h27;
  localparam logic [6:0] LINE2_FIRST = 7'h40;
  localparam logic [6:0] LINE2_LAST = 7'h67;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] CLEAR_CODE = 8'h01;
  // APB map
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [15:0] BLINK_HALF_RST = 16'h0400;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] xfer;
    logic [6:0] addr_pointer;
    logic to_glyph;
    logic inc;
    logic whole_view_scroll;
    logic disp;
    logic curs;
    logic flash;
    logic bus_width_sel;
    logic two_line;
    logic tall;
    logic [6:0] view;
    logic busy;
    logic [BUSY_W-1:0] busy_cnt;
    logic nib_lo;
    logic [3:0] nib_hi;
    logic e_prev;
    logic [7:0] rd_byte;
    logic [7:0] db_o;
    logic db_oe_n;
    logic [15:0] blink_half;
    logic [15:0] blink_cnt;
    logic blink_ph;
    logic [7:0] cur_cell;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [TEXT_DEPTH-1:0][7:0] text;
    logic [GLYPH_DEPTH-1:0][7:0] glyph;
  } lcdie_state_s;

  localparam lcdie_state_s RST_STATE = '{inc: 1'b1, bus_width_sel: 1'b1,
    db_oe_n: 1'b1, blink_half: BLINK_HALF_RST,
    text: {TEXT_DEPTH{SPACE_CODE}}, default: '0};
endpackage

// ---- verilog/lcdie_engine.sv ----
// Instruction engine of a two-line character display controller.
// Host parallel port pins are synchronous to pclk; APB gives status.
//
// Summary of operation
// - Host transfers land in holding registers, then execute internally.
// - Address pointer steps by one after every memory access.
// - Busy shows as one on DB7 while executing.
// - Clear fills text with 20H, pointer 00H, increment mode.
// - Home sets pointer 00H, undoes shift, keeps text.
// - Entry mode stores direction (DB1) and scroll (DB0).
// - Glyph accesses step like text accesses.
// - Of data accesses, only a text write with scroll set shifts the view.
// - Display bit DB2 blanks panel, text kept.
// - Cursor bit DB1 shows cursor, direction kept.
// - Flash bit alternates cursor cell with all ones.
// - Shift instruction touches no memory.
// - Two-line: past position 40 of line one goes to line two.
// - View shift moves all lines and keeps pointer.
// - Target 0 moves cursor; target 1 shifts view.
// - Width bit selects 8-bit or two-nibble 4-bit transfers.
// - Row bit picks line count; height bit picks glyph format.
// - DB6 instruction loads 6-bit glyph address.
// - DB7 instruction loads 7-bit text address.
// - Text addresses depend on one- or two-line mode.
// - Status read gives busy and 7-bit pointer.
// - Status read is select 0, read 1.
// - Function set decoded from DB5 with DB7, DB6 clear.
// - Busy lasts 1.53 ms, 39 us or 43 us.
// - 4-bit mode uses DB7..DB4, upper nibble first.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
module lcdie_engine import lcdie_pkg::*; #(
  parameter int CLR_CYCLES = CLR_CYC,
  parameter int CMD_CYCLES = CMD_CYC,
  parameter int DATA_CYCLES = DATA_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic register_select_line,
  input wire logic rw_line,
  input wire logic strobe,
  input wire logic [7:0] db_i,
  output logic [7:0] db_o,
  output logic db_oe_n,
  output logic busy_indicator,
  output logic disp_on,
  output logic cursor_on,
  output logic two_line,
  output logic tall_glyph,
  output logic [6:0] view_offset,
  output logic [6:0] addr_pointer,
  output logic [7:0] cursor_cell
);
  localparam logic [BUSY_W-1:0] CLR_N = BUSY_W'(CLR_CYCLES);
  localparam logic [BUSY_W-1:0] CMD_N = BUSY_W'(CMD_CYCLES);
  localparam logic [BUSY_W-1:0] DATA_N = BUSY_W'(DATA_CYCLES);
  localparam logic [BUSY_W-1:0] CNT_ONE = BUSY_W'(1);

  lcdie_state_s s_q, s_d;
  logic rise, fall, done, acc_cmd, acc_wr, acc_rd, idx_ok;
  logic [7:0] byte_in, mem_byte;
  logic [6:0] cur_idx;

  // Text address to storage index; line two packs after line one
  // Addresses outside both lines are screened by idx_ok
  function automatic logic [6:0] lcdie_tidx(input logic [6:0] a, input logic two);
    if (two && a[6]) return 7'(a - LINE2_FIRST + LINE_LEN);
    return a;
  endfunction

  // Pointer step with the wrap points of each address space
  function automatic logic [6:0] lcdie_step(input logic [6:0] a, input logic up,
                                            input logic two, input logic gl);
    logic [6:0] r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (gl) r = {1'b0, r[5:0]};
    else if (two) begin
      if (up && a == LINE1_LAST) r = LINE2_FIRST;
      else if (up && a == LINE2_LAST) r = HOME_ADDR;
      else if (!up && a == LINE2_FIRST) r = LINE1_LAST;
      else if (!up && a == HOME_ADDR) r = LINE2_LAST;
    end else begin
      if (up && a == ONE_LAST) r = HOME_ADDR;
      else if (!up && a == HOME_ADDR) r = ONE_LAST;
    end
    return r;
  endfunction

  // View offset rotates within one line span
  function automatic logic [6:0] lcdie_vshift(input logic [6:0] v, input logic left,
                                              input logic two);
    logic [6:0] last;
    last = two ? 7'(LINE_LEN - 7'h01) : 7'(ONE_SPAN - 7'h01);
    if (left) return (v >= last) ? HOME_ADDR : 7'(v + 7'h01);
    return (v == HOME_ADDR) ? last : 7'(v - 7'h01);
  endfunction

  // Strobe edges and byte assembly
  assign rise = strobe & ~s_q.e_prev;
  assign fall = ~strobe & s_q.e_prev;
  assign done = fall & (s_q.bus_width_sel | s_q.nib_lo);
  assign byte_in = s_q.bus_width_sel ? db_i : {s_q.nib_hi, db_i[7:4]};
  // Writes during busy are dropped; the host must poll first
  assign acc_cmd = done & ~rw_line & ~register_select_line & ~s_q.busy;
  assign acc_wr = done & ~rw_line & register_select_line & ~s_q.busy;
  assign acc_rd = done & rw_line & register_select_line;
  assign cur_idx = lcdie_tidx(s_q.addr_pointer, s_q.two_line);
  // Only valid text ranges have storage; the tail of line one must not alias line two
  assign idx_ok = s_q.two_line
                ? (s_q.addr_pointer <= LINE1_LAST
                   || (s_q.addr_pointer >= LINE2_FIRST && s_q.addr_pointer <= LINE2_LAST))
                : (s_q.addr_pointer <= ONE_LAST);
  assign mem_byte = s_q.to_glyph ? s_q.glyph[s_q.addr_pointer[5:0]]
                  : (idx_ok ? s_q.text[cur_idx] : '0);

  // Next-state logic for the whole engine
  always_comb begin
    logic [7:0] rb;
    rb = s_q.rd_byte;
    s_d = s_q;
    s_d.e_prev = strobe;
    // Busy countdown
    // A new access further down reloads it, so a set wins over the clear
    if (s_q.busy) begin
      if (s_q.busy_cnt == CNT_ONE) begin
        s_d.busy = 1'b0;
        s_d.busy_cnt = '0;
      end else begin
        s_d.busy_cnt = BUSY_W'(s_q.busy_cnt - CNT_ONE);
      end
    end
    // Nibble phase in 4-bit mode
    if (fall && !s_q.bus_width_sel) begin
      s_d.nib_lo = ~s_q.nib_lo;
      if (!s_q.nib_lo) s_d.nib_hi = db_i[7:4];
    end
    // Read drive; byte captured on the first rising strobe
    if (strobe && rw_line) begin
      if (rise && (s_q.bus_width_sel || !s_q.nib_lo)) begin
        rb = register_select_line ? mem_byte : {s_q.busy, s_q.addr_pointer};
        s_d.rd_byte = rb;
      end
      if (s_q.bus_width_sel) s_d.db_o = rb;
      else s_d.db_o = s_q.nib_lo ? {rb[3:0], 4'h0} : {rb[7:4], 4'h0};
      s_d.db_oe_n = 1'b0;
    end else begin
      s_d.db_oe_n = 1'b1;
    end
    // Data read completes: step only, no scroll
    if (acc_rd) begin
      s_d.addr_pointer = lcdie_step(s_q.addr_pointer, s_q.inc, s_q.two_line, s_q.to_glyph);
      s_d.busy = 1'b1;
      s_d.busy_cnt = DATA_N;
    end
    // Data write through the transfer holding register
    if (acc_wr) begin
      s_d.xfer = byte_in;
      if (s_q.to_glyph) s_d.glyph[s_q.addr_pointer[5:0]] = byte_in;
      else if (idx_ok) s_d.text[cur_idx] = byte_in;
      if (!s_q.to_glyph && s_q.whole_view_scroll)
        s_d.view = lcdie_vshift(s_q.view, s_q.inc, s_q.two_line);
      s_d.addr_pointer = lcdie_step(s_q.addr_pointer, s_q.inc, s_q.two_line, s_q.to_glyph);
      s_d.busy = 1'b1;
      s_d.busy_cnt = DATA_N;
    end
    // Instruction decode, highest set bit wins
    if (acc_cmd) begin
      s_d.cmd = byte_in;
      s_d.busy = 1'b1;
      s_d.busy_cnt = CMD_N;
      if (byte_in[7]) begin
        s_d.addr_pointer = byte_in[6:0];
        s_d.to_glyph = 1'b0;
      end else if (byte_in[6]) begin
        s_d.addr_pointer = {1'b0, byte_in[5:0]};
        s_d.to_glyph = 1'b1;
      end else if (byte_in[5]) begin
        s_d.bus_width_sel = byte_in[4];
        s_d.two_line = byte_in[3];
        s_d.tall = byte_in[2];
        s_d.nib_lo = 1'b0;
      end else if (byte_in[4]) begin
        if (byte_in[3]) s_d.view = lcdie_vshift(s_q.view, ~byte_in[2], s_q.two_line);
        else s_d.addr_pointer = lcdie_step(s_q.addr_pointer, byte_in[2], s_q.two_line,
                                           s_q.to_glyph);
      end else if (byte_in[3]) begin
        s_d.disp = byte_in[2];
        s_d.curs = byte_in[1];
        s_d.flash = byte_in[0];
      end else if (byte_in[2]) begin
        s_d.inc = byte_in[1];
        s_d.whole_view_scroll = byte_in[0];
      end else if (byte_in[1]) begin
        s_d.addr_pointer = HOME_ADDR;
        s_d.view = HOME_ADDR;
        s_d.to_glyph = 1'b0;
        s_d.busy_cnt = CLR_N;
      end else if (byte_in[0]) begin
        s_d.text = {TEXT_DEPTH{SPACE_CODE}};
        s_d.addr_pointer = HOME_ADDR;
        s_d.view = HOME_ADDR;
        s_d.inc = 1'b1;
        s_d.to_glyph = 1'b0;
        s_d.busy_cnt = CLR_N;
      end
    end
    // Flash phase; period set by software
    if (s_q.blink_cnt >= s_q.blink_half) begin
      s_d.blink_cnt = '0;
      s_d.blink_ph = ~s_q.blink_ph;
    end else begin
      s_d.blink_cnt = 16'(s_q.blink_cnt + 16'h0001);
    end
    s_d.cur_cell = (s_q.flash && s_q.blink_ph) ? ALL_ONES
                 : (idx_ok ? s_q.text[cur_idx] : SPACE_CODE);
    // APB slave: one wait state, error on unmapped offsets
    // Config writes land only at the edge after the one that shows pready
    s_d.pready = psel & penable & ~s_q.pready;
    if (psel && penable && !s_q.pready) begin
      s_d.pslverr = (paddr != CFG_OFS) && (paddr != STAT_OFS);
      if (paddr == CFG_OFS) s_d.prdata = {16'h0000, s_q.blink_half};
      else if (paddr == STAT_OFS)
        s_d.prdata = {8'h00, s_q.tall, s_q.two_line, s_q.bus_width_sel, s_q.flash,
                      s_q.curs, s_q.disp, s_q.whole_view_scroll, s_q.inc,
                      s_q.to_glyph, s_q.view, s_q.busy, s_q.addr_pointer};
      else s_d.prdata = '0;
    end
    if (psel && penable && s_q.pready && pwrite && paddr == CFG_OFS)
      s_d.blink_half = pwdata[15:0];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= RST_STATE;
    else s_q <= s_d;
  end

  // Outputs straight from flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign db_o = s_q.db_o;
  assign db_oe_n = s_q.db_oe_n;
  assign busy_indicator = s_q.busy;
  assign disp_on = s_q.disp;
  assign cursor_on = s_q.curs;
  assign two_line = s_q.two_line;
  assign tall_glyph = s_q.tall;
  assign view_offset = s_q.view;
  assign addr_pointer = s_q.addr_pointer;
  assign cursor_cell = s_q.cur_cell;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_status;
    rise && rw_line && !register_select_line && s_q.bus_width_sel
      |=> db_o == {$past(s_q.busy), $past(s_q.addr_pointer)} && !db_oe_n;
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");
  property p_clear;
    acc_cmd && byte_in == CLEAR_CODE |=> s_q.addr_pointer == HOME_ADDR && s_q.inc
      && s_q.text[0] == SPACE_CODE && s_q.text[TEXT_DEPTH-1] == SPACE_CODE
      && s_q.busy_cnt == CLR_N;
  endproperty
  a_clear: assert property (p_clear) else $error("clear incomplete");
  property p_home;
    acc_cmd && byte_in[7:1] == 7'h01 |=> s_q.view == HOME_ADDR
      && s_q.addr_pointer == HOME_ADDR && s_q.text == $past(s_q.text);
  endproperty
  a_home: assert property (p_home) else $error("home wrong");
  property p_wrap;
    acc_wr && s_q.two_line && s_q.inc && !s_q.to_glyph && s_q.addr_pointer == LINE1_LAST
      |=> s_q.addr_pointer == LINE2_FIRST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to line two");
  property p_dec;
    (acc_wr || acc_rd) && !s_q.inc && (s_q.to_glyph || !s_q.two_line) && s_q.addr_pointer != HOME_ADDR
      |=> s_q.addr_pointer == 7'($past(s_q.addr_pointer) - 7'h01);
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");
  property p_noscroll;
    acc_rd || (acc_wr && s_q.to_glyph) |=> $stable(s_q.view);
  endproperty
  a_noscroll: assert property (p_noscroll) else $error("view moved");
  property p_vshift;
    acc_cmd && byte_in[7:3] == 5'h03 |=> $stable(s_q.addr_pointer) && $stable(s_q.text);
  endproperty
  a_vshift: assert property (p_vshift) else $error("view shift moved pointer");
  property p_curs_right;
    acc_cmd && byte_in[7:2] == 6'h05 && !s_q.two_line && !s_q.to_glyph
      && s_q.addr_pointer < ONE_LAST |=> s_q.addr_pointer == 7'($past(s_q.addr_pointer) + 7'h01);
  endproperty
  a_curs_right: assert property (p_curs_right) else $error("cursor right wrong");
  property p_busy_end;
    s_q.busy && s_q.busy_cnt == CNT_ONE |=> !busy_indicator;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy overruns");
  property p_busy_data;
    acc_wr |=> busy_indicator ##1 busy_indicator && s_q.busy_cnt == DATA_N - CNT_ONE;
  endproperty
  a_busy_data: assert property (p_busy_data) else $error("data busy time");
  property p_ctrl;
    acc_cmd && byte_in[7:3] == 5'h01 |=> disp_on == $past(byte_in[2])
      && cursor_on == $past(byte_in[1]) && $stable(s_q.inc);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("display control wrong");

  // Decode and timing checks
  property p_width;
    acc_cmd && byte_in[7:5] == 3'b001 |=> s_q.bus_width_sel == $past(byte_in[4])
      && two_line == $past(byte_in[3]) && tall_glyph == $past(byte_in[2]) && !s_q.nib_lo;
  endproperty
  a_width: assert property (p_width) else $error("function set wrong");
  property p_glyph_sel;
    acc_cmd && byte_in[7:6] == 2'b01 |=> s_q.to_glyph && addr_pointer == {1'b0, $past(byte_in[5:0])};
  endproperty
  a_glyph_sel: assert property (p_glyph_sel) else $error("glyph address set wrong");
  property p_text_sel;
    acc_cmd && byte_in[7] |=> !s_q.to_glyph && addr_pointer == $past(byte_in[6:0]);
  endproperty
  a_text_sel: assert property (p_text_sel) else $error("text address set wrong");
  property p_entry;
    acc_cmd && byte_in[7:2] == 6'h01 |=> s_q.inc == $past(byte_in[1])
      && s_q.whole_view_scroll == $past(byte_in[0]);
  endproperty
  a_entry: assert property (p_entry) else $error("entry mode wrong");
  property p_busy_cmd;
    acc_cmd && byte_in[7:2] != 6'h00 |=> busy_indicator && s_q.busy_cnt == CMD_N;
  endproperty
  a_busy_cmd: assert property (p_busy_cmd) else $error("instruction busy time");
  property p_home_busy;
    acc_cmd && byte_in[7:2] == 6'h00 && byte_in[1:0] != 2'b00 |=> busy_indicator && s_q.busy_cnt == CLR_N;
  endproperty
  a_home_busy: assert property (p_home_busy) else $error("clear or home busy time");
  property p_curs_left;
    acc_cmd && byte_in[7:2] == 6'h04 && !s_q.two_line && !s_q.to_glyph
      && s_q.addr_pointer != HOME_ADDR |=> s_q.addr_pointer == 7'($past(s_q.addr_pointer) - 7'h01);
  endproperty
  a_curs_left: assert property (p_curs_left) else $error("cursor left wrong");
  property p_rd_step;
    acc_rd && s_q.inc && s_q.to_glyph && s_q.addr_pointer[5:0] != 6'h3f
      |=> addr_pointer == 7'($past(s_q.addr_pointer) + 7'h01);
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("glyph read step wrong");

  // Port drive and display checks
  property p_oe;
    !(strobe && rw_line) |=> db_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven outside a read");
  property p_flash_off;
    !s_q.flash && idx_ok && s_q.text[cur_idx] != ALL_ONES |=> cursor_cell != ALL_ONES;
  endproperty
  a_flash_off: assert property (p_flash_off) else $error("cursor flashes while off");
  property p_view_scroll;
    acc_wr && !s_q.to_glyph && s_q.whole_view_scroll && s_q.inc && !s_q.two_line
      && s_q.view < ONE_LAST |=> view_offset == 7'($past(s_q.view) + 7'h01);
  endproperty
  a_view_scroll: assert property (p_view_scroll) else $error("scroll on write wrong");

  c_clear: cover property (acc_cmd && byte_in == CLEAR_CODE);
  c_nibble: cover property (done && !s_q.bus_width_sel);
  c_scroll: cover property (acc_wr && s_q.whole_view_scroll);
  c_view_shift: cover property (acc_cmd && byte_in[7:3] == 5'h03);
  c_busy_poll: cover property (rise && rw_line && !register_select_line && s_q.busy);
endmodule

// ---- bench/lcdie_host_model.sv ----
// Host processor model for the parallel port of the engine.
// Assumes pclk-synchronous pins; the bench calls its tasks.
`timescale 1ns/10ps
module lcdie_host_model #(
  parameter int HALF_OSC = 2
) (
  input wire logic pclk,
  input wire logic [7:0] db_o,
  input wire logic db_oe_n,
  output logic register_select_line,
  output logic rw_line,
  output logic strobe,
  output logic [7:0] db_i
);
  logic four_bit = 1'b0;
  initial begin
    register_select_line = 1'b0;
    rw_line = 1'b1;
    strobe = 1'b0;
    db_i = 8'h00;
  end
  // One strobe; released bus shows the inverse, not a stale value
  task put(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(posedge pclk);
    register_select_line <= r;
    rw_line <= w;
    db_i <= d;
    strobe <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    q = (db_oe_n === 1'b0) ? db_o : 8'hxx;
    @(posedge pclk);
    strobe <= 1'b0;
    @(posedge pclk);
    db_i <= ~d;
  endtask
  // Whole byte, split in two when the narrow bus is chosen
  task xfer(input logic r, input logic w, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] h;
    if (four_bit) begin
      put(r, w, {d[7:4], ~d[3:0]}, h);
      put(r, w, {d[3:0], ~d[7:4]}, q);
      q = {h[7:4], q[7:4]};
    end else begin
      put(r, w, d, q);
    end
    // Track our own width choice so the next byte is split to match
    if (!r && !w && d[7:5] == 3'b001) four_bit = ~d[4];
  endtask
  // Poll busy, then keep the settling gap before the next strobe
  task poll(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
      ok = (s[7] === 1'b0);
    end
    repeat (HALF_OSC) @(posedge pclk);
  endtask
endmodule

// ---- bench/char_lcd_instruction_engine_bench.sv ----
// Self-checking bench for the display instruction engine.
// Assumes the host model file; short busy counts keep the run brief.
`timescale 1ns/10ps
module char_lcd_instruction_engine_bench;
  import lcdie_pkg::*;
  localparam int CLR = 40;
  localparam int CMD = 8;
  localparam int DAT = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sel_line, rw, strobe, db_oe_n, busy, disp_on, cursor_on, two_line, tall_glyph;
  logic [7:0] db_i, db_o, cursor_cell, q;
  logic [6:0] view_offset, addr_pointer;
  logic [31:0] r;
  logic e, ok;
  int bad_count = 0;
  int comparisons = 0;
  int c;
  always #2 pclk = ~pclk;
  lcdie_engine #(.CLR_CYCLES(CLR), .CMD_CYCLES(CMD), .DATA_CYCLES(DAT)) dut (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .register_select_line(sel_line), .rw_line(rw), .strobe(strobe), .db_i(db_i), .db_o(db_o),
    .db_oe_n(db_oe_n), .busy_indicator(busy), .disp_on(disp_on), .cursor_on(cursor_on),
    .two_line(two_line), .tall_glyph(tall_glyph), .view_offset(view_offset),
    .addr_pointer(addr_pointer), .cursor_cell(cursor_cell));
  lcdie_host_model host (.pclk(pclk), .db_o(db_o), .db_oe_n(db_oe_n), .register_select_line(sel_line),
    .rw_line(rw), .strobe(strobe), .db_i(db_i));
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask
  task results();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // APB transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      results();
    end
  endtask
  // Host access, busy window count, then a status poll
  task ex(input logic s, input logic w, input logic [7:0] b, input int n);
    c = 0;
    host.xfer(s, w, b, q);
    for (int i = 0; i < 2 * n + 8; i++) begin
      @(negedge pclk);
      if (busy === 1'b1) c++;
    end
    chk("busy cycles", n, c);
    host.poll(ok);
    chk("ready", 1, ok);
    if (ok !== 1'b1) results();
  endtask
  // Cycles showing the all-ones cell in a fixed window
  task fl();
    c = 0;
    repeat (40) begin
      @(negedge pclk);
      if (cursor_cell === 8'hff) c++;
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("oe_n", 1, db_oe_n);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("status", 32'h0021_0000, r);
    apb(1'b0, CFG_OFS, 32'h0);
    chk("cfg", 32'h400, r);
    apb(1'b1, 8'h08, 32'h5);
    chk("slverr", 1, e);
    apb(1'b1, CFG_OFS, 32'h3);
    apb(1'b0, CFG_OFS, 32'h0);
    chk("cfg", 32'h3, r);
    ex(1'b0, 1'b0, 8'h0c, CMD);
    chk("disp", 1, disp_on);
    ex(1'b0, 1'b0, 8'h85, CMD);
    chk("pointer", 5, addr_pointer);
    ex(1'b1, 1'b0, 8'h41, DAT);
    chk("pointer", 6, addr_pointer);
    ex(1'b0, 1'b0, 8'h04, CMD);
    ex(1'b1, 1'b0, 8'h42, DAT);
    chk("pointer", 5, addr_pointer);
    ex(1'b1, 1'b1, 8'h00, DAT);
    chk("data", 8'h41, q);
    host.xfer(1'b0, 1'b0, 8'h06, q);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    chk("status", 8'h84, q);
    host.poll(ok);
    ex(1'b0, 1'b0, 8'h14, CMD);
    chk("pointer", 5, addr_pointer);
    ex(1'b0, 1'b0, 8'h10, CMD);
    chk("pointer", 4, addr_pointer);
    ex(1'b0, 1'b0, 8'h18, CMD);
    chk("view", 1, view_offset);
    chk("pointer", 4, addr_pointer);
    ex(1'b0, 1'b0, 8'h02, CLR);
    chk("pointer", 0, addr_pointer);
    chk("view", 0, view_offset);
    ex(1'b0, 1'b0, 8'h85, CMD);
    ex(1'b1, 1'b1, 8'h00, DAT);
    chk("data", 8'h41, q);
    ex(1'b0, 1'b0, 8'h07, CMD);
    ex(1'b1, 1'b0, 8'h43, DAT);
    chk("view", 1, view_offset);
    ex(1'b0, 1'b0, 8'h43, CMD);
    chk("pointer", 3, addr_pointer);
    ex(1'b1, 1'b0, 8'h1f, DAT);
    chk("pointer", 4, addr_pointer);
    chk("view", 1, view_offset);
    ex(1'b0, 1'b0, 8'h43, CMD);
    ex(1'b1, 1'b1, 8'h00, DAT);
    chk("glyph", 8'h1f, q);
    ex(1'b0, 1'b0, 8'h0f, CMD);
    chk("cursor", 1, cursor_on);
    fl();
    chk("flash", 1, c > 0 && c < 40);
    ex(1'b0, 1'b0, 8'h05, CMD);
    ex(1'b0, 1'b0, 8'h0c, CMD);
    fl();
    chk("flash", 0, c);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("inc", 0, r[16]);
    ex(1'b0, 1'b0, 8'h06, CMD);
    ex(1'b0, 1'b0, 8'h3c, CMD);
    chk("rows", 1, two_line);
    chk("tall", 1, tall_glyph);
    ex(1'b0, 1'b0, 8'ha7, CMD);
    ex(1'b1, 1'b0, 8'h44, DAT);
    chk("pointer", 7'h40, addr_pointer);
    ex(1'b0, 1'b0, 8'h04, CMD);
    ex(1'b0, 1'b0, 8'h01, CLR);
    chk("pointer", 0, addr_pointer);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("inc", 1, r[16]);
    ex(1'b0, 1'b0, 8'h85, CMD);
    ex(1'b1, 1'b1, 8'h00, DAT);
    chk("data", 8'h20, q);
    ex(1'b0, 1'b0, 8'h28, CMD);
    chk("tall", 0, tall_glyph);
    ex(1'b0, 1'b0, 8'h90, CMD);
    chk("pointer", 7'h10, addr_pointer);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    chk("status", 8'h10, q);
    ex(1'b1, 1'b0, 8'h5a, DAT);
    ex(1'b0, 1'b0, 8'h90, CMD);
    ex(1'b1, 1'b1, 8'h00, DAT);
    chk("data", 8'h5a, q);
    results();
  end
endmodule
